/* hdl/gist_pkg.sv */
// Purpose: Shared constants and types for both ends of the gauge link.
// Assumes: A 100 MHz system clock on both ends.
// Notes: Long counts are offered again as module parameters.
// Summary of operation
// - Release both lines after two seconds low.
// - Host waits 66 us after subcommands, reads.
// - Host waits 100 ms after checksum subcommand.
// - Host waits two seconds after read-write commands.
// - Standard commands at most twice per second.
// - Deep power modes stretch on all traffic.
// - Normal modes stretch only on own address.
// - Stretch after start, acknowledge, first read bit.
// - Ordinary flow-control stretches stay under 4 ms.
// - Resistance table update stretches up to 24 ms.
// - At most 15 table updates per discharge.
// - Block write stretches up to 72 ms.
// - Block rewrite phase takes 44 ms.
// - Interrupted write restore adds 44 ms, 116 total.
// - End of discharge stretches up to 144 ms.
package gist_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1_000;
	localparam int SCL_HZ = 400_000;
	localparam int HALF_INT = (CLK_HZ + 2 * SCL_HZ - 1) / (2 * SCL_HZ);

	typedef logic [27:0] gist_timer_t;
	localparam gist_timer_t TIMER_ONE = 28'h0000001;
	localparam gist_timer_t HALF_LAST = gist_timer_t'(HALF_INT - 1);

	localparam int BUS_TIMEOUT_S = 2;
	localparam int WAKE_STRETCH_US = 20;
	localparam int FLOW_STRETCH_US = 5;
	localparam int FLOW_STRETCH_MAX_MS = 4;
	localparam int TABLE_STRETCH_MS = 24;
	localparam int BLOCK_UPDATE_MS = 44;
	localparam int BLOCK_WRITE_MS = 72;
	localparam int RESTORE_TOTAL_MS = 116;
	localparam int EOD_STRETCH_MS = 144;
	localparam int SUBCMD_GAP_US = 66;
	localparam int CHECKSUM_GAP_MS = 100;
	localparam int RW_STD_GAP_S = 2;
	localparam int STD_CMDS_PER_S = 2;
	localparam int HOST_STRETCH_LIMIT_MS = 150;

	localparam gist_timer_t BUS_TIMEOUT_CYC =
		gist_timer_t'(BUS_TIMEOUT_S * CLK_HZ);
	localparam gist_timer_t WAKE_STRETCH_CYC =
		gist_timer_t'(WAKE_STRETCH_US * CYC_PER_US);
	localparam gist_timer_t FLOW_STRETCH_CYC = (FLOW_STRETCH_US * CYC_PER_US
		< FLOW_STRETCH_MAX_MS * CYC_PER_MS) ?
		gist_timer_t'(FLOW_STRETCH_US * CYC_PER_US) :
		gist_timer_t'(FLOW_STRETCH_MAX_MS * CYC_PER_MS);
	localparam gist_timer_t TABLE_STRETCH_CYC =
		gist_timer_t'(TABLE_STRETCH_MS * CYC_PER_MS);
	localparam gist_timer_t BLOCK_WRITE_CYC =
		gist_timer_t'(BLOCK_WRITE_MS * CYC_PER_MS);
	localparam gist_timer_t RESTORE_TOTAL_CYC =
		gist_timer_t'(RESTORE_TOTAL_MS * CYC_PER_MS);
	localparam gist_timer_t EOD_STRETCH_CYC =
		gist_timer_t'(EOD_STRETCH_MS * CYC_PER_MS);
	localparam gist_timer_t EOD_PLAIN_CYC =
		gist_timer_t'(2 * BLOCK_UPDATE_MS * CYC_PER_MS);
	localparam gist_timer_t SUBCMD_GAP_CYC =
		gist_timer_t'(SUBCMD_GAP_US * CYC_PER_US);
	localparam gist_timer_t CHECKSUM_GAP_CYC =
		gist_timer_t'(CHECKSUM_GAP_MS * CYC_PER_MS);
	localparam gist_timer_t RW_STD_GAP_CYC =
		gist_timer_t'(RW_STD_GAP_S * CLK_HZ);
	localparam gist_timer_t STD_SPACING_CYC =
		gist_timer_t'(CLK_HZ / STD_CMDS_PER_S);
	localparam gist_timer_t HOST_STRETCH_CYC =
		gist_timer_t'(HOST_STRETCH_LIMIT_MS * CYC_PER_MS);

	localparam logic [6:0] DEV_ADDR = 7'h55;
	localparam logic [3:0] FIRST_BIT = 4'h0;
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [3:0] BIT_ONE = 4'h1;
	// Parks the bit counter until the clock fall that follows a start.
	localparam logic [3:0] START_BIT = 4'hf;
	localparam logic [3:0] TABLE_UPDATES_MAX = 4'hf;
	localparam logic [7:0] RELEASE_BYTE = 8'hff;

	typedef enum logic [1:0] {
		PM_NORMAL = 2'h0,
		PM_LIGHT_SLEEP = 2'h1,
		PM_SLEEP = 2'h2,
		PM_DEEPEST_DOZE = 2'h3
	} gist_power_e;
	typedef enum logic [1:0] {
		OP_TABLE_UPDATE = 2'h0,
		OP_BLOCK_WRITE = 2'h1,
		OP_BLOCK_RESTORE = 2'h2,
		OP_END_DISCHARGE = 2'h3
	} gist_op_e;
	typedef enum logic [1:0] {
		GAP_SUBCMD = 2'h0,
		GAP_CHECKSUM = 2'h1,
		GAP_RW_STD = 2'h2,
		GAP_RO_STD = 2'h3
	} gist_gap_e;
	typedef enum logic [2:0] {
		D_IDLE = 3'h0,
		D_ADDR = 3'h1,
		D_WRITE = 3'h2,
		D_READ = 3'h3,
		D_WAIT_STOP = 3'h4
	} gist_dev_state_e;
	typedef enum logic [3:0] {
		H_IDLE = 4'h0,
		H_START = 4'h1,
		H_LOW = 4'h2,
		H_RISE = 4'h3,
		H_HIGH = 4'h4,
		H_STOP_LOW = 4'h5,
		H_STOP_RISE = 4'h6,
		H_STOP_HIGH = 4'h7,
		H_GAP = 4'h8
	} gist_host_state_e;
endpackage

/* hdl/gist_if.sv */
// Purpose: Open-drain clock and data lines between host and gauge.
// Assumes: Each end drives a line low only while its enable is high.
// Notes: Pull-ups are modelled by the default high level.
`timescale 1ns/1ns
interface gist_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_scl_o;
	logic dev_scl_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	assign scl = !((host_scl_oe && !host_scl_o) || (dev_scl_oe && !dev_scl_o));
	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
	modport host (
		output host_scl_o,
		output host_scl_oe,
		output host_sda_o,
		output host_sda_oe,
		input scl,
		input sda
	);
	modport dev (
		output dev_scl_o,
		output dev_scl_oe,
		output dev_sda_o,
		output dev_sda_oe,
		input scl,
		input sda
	);
endinterface

/* hdl/gist_device.sv */
// Purpose: Gauge end of the link: slave framing, stretching, bus timeout.
// Assumes: Lines come from gist_if and are synchronised here.
// Notes: Flash work is seen only as the length of the stretch it causes.
`timescale 1ns/1ns
module gist_device #(
	parameter gist_pkg::gist_timer_t BUS_TIMEOUT_CYC = gist_pkg::BUS_TIMEOUT_CYC,
	parameter gist_pkg::gist_timer_t WAKE_CYC = gist_pkg::WAKE_STRETCH_CYC,
	parameter gist_pkg::gist_timer_t FLOW_CYC = gist_pkg::FLOW_STRETCH_CYC,
	parameter gist_pkg::gist_timer_t TABLE_CYC = gist_pkg::TABLE_STRETCH_CYC,
	parameter gist_pkg::gist_timer_t BLOCK_CYC = gist_pkg::BLOCK_WRITE_CYC,
	parameter gist_pkg::gist_timer_t RESTORE_CYC =
		gist_pkg::RESTORE_TOTAL_CYC,
	parameter gist_pkg::gist_timer_t EOD_CYC = gist_pkg::EOD_STRETCH_CYC,
	parameter gist_pkg::gist_timer_t EOD_PLAIN_CYC = gist_pkg::EOD_PLAIN_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	gist_if.dev link,
	input wire gist_pkg::gist_power_e power_mode,
	input wire logic op_req,
	input wire gist_pkg::gist_op_e op_kind,
	input wire logic discharge_start,
	input wire logic [7:0] tx_data,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic stretching,
	output logic bus_timeout
);
	logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
	gist_pkg::gist_dev_state_e state, next_state;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] shreg, next_shreg;
	logic rnw, next_rnw;
	logic mst_ack, next_mst_ack;
	logic sda_oe, next_sda_oe;
	gist_pkg::gist_timer_t stretch_cnt, next_stretch_cnt;
	logic wake_pend, next_wake_pend;
	logic op_pend, next_op_pend;
	gist_pkg::gist_timer_t op_len, next_op_len;
	logic [3:0] tbl_cnt, next_tbl_cnt;
	logic tbl_seen, next_tbl_seen;
	gist_pkg::gist_timer_t to_cnt, next_to_cnt;
	logic timed_out, next_timed_out;
	logic [7:0] next_rx_data;
	logic next_rx_valid;
	logic scl_rise, scl_fall, start_seen, stop_seen, in_frame, accept;
	gist_pkg::gist_timer_t point_len;

	// Worst-case stretch for each kind of flash work.
	function automatic gist_pkg::gist_timer_t op_cycles(
		input gist_pkg::gist_op_e kind,
		input logic table_done
	);
		case (kind)
			gist_pkg::OP_TABLE_UPDATE: op_cycles = TABLE_CYC;
			gist_pkg::OP_BLOCK_WRITE: op_cycles = BLOCK_CYC;
			gist_pkg::OP_BLOCK_RESTORE: op_cycles = RESTORE_CYC;
			default: op_cycles = table_done ? EOD_CYC : EOD_PLAIN_CYC;
		endcase
	endfunction

	assign link.dev_scl_o = 1'b0;
	assign link.dev_sda_o = 1'b0;
	assign link.dev_scl_oe = (stretch_cnt != '0);
	assign link.dev_sda_oe = sda_oe;
	assign stretching = link.dev_scl_oe;
	assign bus_timeout = timed_out;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_p <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_p <= 1'b1;
		end else if (ce) begin
			scl_m <= link.scl;
			scl_s <= scl_m;
			scl_p <= scl_s;
			sda_m <= link.sda;
			sda_s <= sda_m;
			sda_p <= sda_s;
		end
	end

	assign scl_rise = scl_s && !scl_p;
	assign scl_fall = !scl_s && scl_p;
	assign start_seen = scl_s && scl_p && sda_p && !sda_s;
	assign stop_seen = scl_s && scl_p && !sda_p && sda_s;
	assign in_frame = (state != gist_pkg::D_IDLE) &&
		(state != gist_pkg::D_WAIT_STOP);
	assign point_len = op_pend ? op_len : FLOW_CYC;
	assign accept = op_req && ((op_kind != gist_pkg::OP_TABLE_UPDATE) ||
		(tbl_cnt != gist_pkg::TABLE_UPDATES_MAX));

	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_shreg = shreg;
		next_rnw = rnw;
		next_mst_ack = mst_ack;
		next_sda_oe = sda_oe;
		next_stretch_cnt = stretch_cnt;
		next_wake_pend = wake_pend;
		next_op_pend = op_pend;
		next_op_len = op_len;
		next_tbl_cnt = tbl_cnt;
		next_tbl_seen = tbl_seen;
		next_to_cnt = to_cnt;
		next_timed_out = timed_out;
		next_rx_data = rx_data;
		next_rx_valid = 1'b0;
		if (stretch_cnt != '0) begin
			next_stretch_cnt = stretch_cnt - gist_pkg::TIMER_ONE;
		end
		if (!scl_s || !sda_s) begin
			if (to_cnt != BUS_TIMEOUT_CYC) begin
				next_to_cnt = to_cnt + gist_pkg::TIMER_ONE;
			end
		end else begin
			next_to_cnt = '0;
		end
		if (timed_out) begin
			next_stretch_cnt = '0;
			next_sda_oe = 1'b0;
			next_state = gist_pkg::D_WAIT_STOP;
			next_timed_out = !(scl_s && sda_s);
		end else if (to_cnt == BUS_TIMEOUT_CYC) begin
			// A stuck line would otherwise hang the host for good.
			next_timed_out = 1'b1;
			next_stretch_cnt = '0;
			next_sda_oe = 1'b0;
			next_state = gist_pkg::D_WAIT_STOP;
		end else if (start_seen) begin
			next_state = gist_pkg::D_ADDR;
			next_bit_cnt = gist_pkg::START_BIT;
			next_sda_oe = 1'b0;
			next_wake_pend = (power_mode == gist_pkg::PM_SLEEP) ||
				(power_mode == gist_pkg::PM_DEEPEST_DOZE);
		end else if (stop_seen) begin
			next_state = gist_pkg::D_IDLE;
			next_sda_oe = 1'b0;
			next_wake_pend = 1'b0;
		end else if (scl_rise && in_frame) begin
			if (bit_cnt == gist_pkg::ACK_BIT) begin
				next_mst_ack = !sda_s;
			end else if (state != gist_pkg::D_READ) begin
				next_shreg = {shreg[6:0], sda_s};
			end
		end else if (scl_fall && in_frame) begin
			// The start's own clock fall ends no bit, so it only arms the count.
			next_bit_cnt = (bit_cnt == gist_pkg::ACK_BIT) ||
				(bit_cnt == gist_pkg::START_BIT) ? gist_pkg::FIRST_BIT :
				bit_cnt + gist_pkg::BIT_ONE;
			if (wake_pend) begin
				// The wake stretch comes before the address is known.
				next_stretch_cnt = WAKE_CYC;
				next_wake_pend = 1'b0;
			end
			case (state)
				gist_pkg::D_ADDR: begin
					if (bit_cnt == gist_pkg::LAST_BIT) begin
						next_sda_oe = (shreg[7:1] == gist_pkg::DEV_ADDR);
						next_rnw = shreg[0];
					end else if (bit_cnt == gist_pkg::ACK_BIT) begin
						if (!sda_oe) begin
							// Other targets' traffic gets no acknowledge stretch, only the wake stretch in deep modes.
							next_state = gist_pkg::D_WAIT_STOP;
						end else begin
							next_stretch_cnt = point_len;
							next_op_pend = 1'b0;
							if (rnw) begin
								next_state = gist_pkg::D_READ;
								next_shreg = tx_data;
								next_sda_oe = !tx_data[7];
							end else begin
								next_state = gist_pkg::D_WRITE;
								next_sda_oe = 1'b0;
							end
						end
					end
				end
				gist_pkg::D_WRITE: begin
					if (bit_cnt == gist_pkg::LAST_BIT) begin
						next_rx_data = shreg;
						next_rx_valid = 1'b1;
						next_sda_oe = 1'b1;
					end else if (bit_cnt == gist_pkg::ACK_BIT) begin
						next_sda_oe = 1'b0;
						next_stretch_cnt = point_len;
						next_op_pend = 1'b0;
					end
				end
				gist_pkg::D_READ: begin
					if (bit_cnt == gist_pkg::ACK_BIT) begin
						if (!mst_ack) begin
							next_state = gist_pkg::D_WAIT_STOP;
							next_sda_oe = 1'b0;
						end else begin
							next_shreg = tx_data;
							next_sda_oe = !tx_data[7];
						end
					end else if (bit_cnt == gist_pkg::LAST_BIT) begin
						next_sda_oe = 1'b0;
					end else begin
						next_shreg = {shreg[6:0], 1'b0};
						next_sda_oe = !shreg[6];
						if (bit_cnt == gist_pkg::FIRST_BIT) begin
							next_stretch_cnt = point_len;
							next_op_pend = 1'b0;
						end
					end
				end
				default: begin
					next_state = gist_pkg::D_WAIT_STOP;
				end
			endcase
		end
		// Requests are taken last so a new one survives a same-cycle use.
		if (discharge_start) begin
			next_tbl_cnt = '0;
			next_tbl_seen = 1'b0;
		end else if (accept) begin
			next_op_pend = 1'b1;
			next_op_len = op_cycles(op_kind, tbl_seen);
			if (op_kind == gist_pkg::OP_TABLE_UPDATE) begin
				next_tbl_cnt = tbl_cnt + gist_pkg::BIT_ONE;
				next_tbl_seen = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= gist_pkg::D_IDLE;
			bit_cnt <= gist_pkg::FIRST_BIT;
			shreg <= '0;
			rnw <= 1'b0;
			mst_ack <= 1'b0;
			sda_oe <= 1'b0;
			stretch_cnt <= '0;
			wake_pend <= 1'b0;
			op_pend <= 1'b0;
			op_len <= '0;
			tbl_cnt <= '0;
			tbl_seen <= 1'b0;
			to_cnt <= '0;
			timed_out <= 1'b0;
			rx_data <= '0;
			rx_valid <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			shreg <= next_shreg;
			rnw <= next_rnw;
			mst_ack <= next_mst_ack;
			sda_oe <= next_sda_oe;
			stretch_cnt <= next_stretch_cnt;
			wake_pend <= next_wake_pend;
			op_pend <= next_op_pend;
			op_len <= next_op_len;
			tbl_cnt <= next_tbl_cnt;
			tbl_seen <= next_tbl_seen;
			to_cnt <= next_to_cnt;
			timed_out <= next_timed_out;
			rx_data <= next_rx_data;
			rx_valid <= next_rx_valid;
		end
	end
endmodule // gist_device

/* hdl/gist_host.sv */
// Purpose: Host end of the link: one-byte transfers with enforced gaps.
// Assumes: Lines come from gist_if and are synchronised here.
// Notes: A read always ends with a not-acknowledge after one byte.
`timescale 1ns/1ns
module gist_host #(
	parameter gist_pkg::gist_timer_t SUBCMD_GAP_CYC = gist_pkg::SUBCMD_GAP_CYC,
	parameter gist_pkg::gist_timer_t CHECKSUM_GAP_CYC =
		gist_pkg::CHECKSUM_GAP_CYC,
	parameter gist_pkg::gist_timer_t RW_STD_GAP_CYC = gist_pkg::RW_STD_GAP_CYC,
	parameter gist_pkg::gist_timer_t STD_SPACING_CYC =
		gist_pkg::STD_SPACING_CYC,
	parameter gist_pkg::gist_timer_t STRETCH_LIMIT_CYC =
		gist_pkg::HOST_STRETCH_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	gist_if.host link,
	input wire logic start,
	input wire logic [6:0] addr,
	input wire logic rnw,
	input wire logic [7:0] wdata,
	input wire gist_pkg::gist_gap_e gap_kind,
	output logic ready,
	output logic done,
	output logic [7:0] rdata,
	output logic ack_err,
	output logic stretch_err
);
	logic scl_m, scl_s, sda_m, sda_s;
	gist_pkg::gist_host_state_e state, next_state;
	gist_pkg::gist_timer_t t, next_t, gap_len, next_gap_len;
	gist_pkg::gist_timer_t std_cnt, next_std_cnt;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic byte_idx, next_byte_idx, rnw_q, next_rnw_q;
	logic [7:0] shreg, next_shreg, wdata_q, next_wdata_q, next_rdata;
	logic scl_oe, next_scl_oe, sda_oe, next_sda_oe;
	logic next_done, next_ack_err, next_stretch_err, drive;

	function automatic logic std_kind(input gist_pkg::gist_gap_e k);
		std_kind = (k == gist_pkg::GAP_RW_STD) || (k == gist_pkg::GAP_RO_STD);
	endfunction

	function automatic gist_pkg::gist_timer_t gap_cycles(
		input gist_pkg::gist_gap_e k
	);
		case (k)
			gist_pkg::GAP_SUBCMD: gap_cycles = SUBCMD_GAP_CYC;
			gist_pkg::GAP_CHECKSUM: gap_cycles = CHECKSUM_GAP_CYC;
			gist_pkg::GAP_RW_STD: gap_cycles = RW_STD_GAP_CYC;
			default: gap_cycles = '0;
		endcase
	endfunction

	assign link.host_scl_o = 1'b0;
	assign link.host_sda_o = 1'b0;
	assign link.host_scl_oe = scl_oe;
	assign link.host_sda_oe = sda_oe;
	// Standard commands are spaced however short their own gap is.
	assign ready = (state == gist_pkg::H_IDLE) && (!std_kind(gap_kind) ||
		(std_cnt == STD_SPACING_CYC));
	assign drive = (bit_cnt != gist_pkg::ACK_BIT) && !(byte_idx && rnw_q) &&
		!shreg[7];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
		end else if (ce) begin
			scl_m <= link.scl;
			scl_s <= scl_m;
			sda_m <= link.sda;
			sda_s <= sda_m;
		end
	end

	always_comb begin
		next_state = state;
		next_t = t + gist_pkg::TIMER_ONE;
		next_gap_len = gap_len;
		next_std_cnt = std_cnt;
		next_bit_cnt = bit_cnt;
		next_byte_idx = byte_idx;
		next_rnw_q = rnw_q;
		next_shreg = shreg;
		next_wdata_q = wdata_q;
		next_rdata = rdata;
		next_scl_oe = scl_oe;
		next_sda_oe = sda_oe;
		next_done = 1'b0;
		next_ack_err = ack_err;
		next_stretch_err = stretch_err;
		if (std_cnt != STD_SPACING_CYC) begin
			next_std_cnt = std_cnt + gist_pkg::TIMER_ONE;
		end
		case (state)
			gist_pkg::H_IDLE: begin
				next_t = '0;
				if (start && ready) begin
					next_state = gist_pkg::H_START;
					next_shreg = {addr, rnw};
					next_rnw_q = rnw;
					next_wdata_q = wdata;
					next_gap_len = gap_cycles(gap_kind);
					next_sda_oe = 1'b1;
					next_ack_err = 1'b0;
					next_stretch_err = 1'b0;
					if (std_kind(gap_kind)) begin
						next_std_cnt = '0;
					end
				end
			end
			gist_pkg::H_START: begin
				if (t == gist_pkg::HALF_LAST) begin
					next_state = gist_pkg::H_LOW;
					next_scl_oe = 1'b1;
					next_t = '0;
					next_bit_cnt = gist_pkg::FIRST_BIT;
					next_byte_idx = 1'b0;
				end
			end
			gist_pkg::H_LOW: begin
				next_sda_oe = drive;
				if (t == gist_pkg::HALF_LAST) begin
					next_scl_oe = 1'b0;
					next_state = gist_pkg::H_RISE;
					next_t = '0;
				end
			end
			gist_pkg::H_RISE, gist_pkg::H_STOP_RISE: begin
				if (scl_s) begin
					next_state = (state == gist_pkg::H_RISE) ?
						gist_pkg::H_HIGH : gist_pkg::H_STOP_HIGH;
					next_t = '0;
				end else if (t == STRETCH_LIMIT_CYC) begin
					// Only a stretch beyond the worst flash case is an error.
					next_stretch_err = 1'b1;
					next_sda_oe = 1'b0;
					next_done = 1'b1;
					next_state = gist_pkg::H_GAP;
					next_t = '0;
				end
			end
			gist_pkg::H_HIGH: begin
				if (t == gist_pkg::HALF_LAST) begin
					next_t = '0;
					next_scl_oe = 1'b1;
					next_state = gist_pkg::H_LOW;
					if (bit_cnt != gist_pkg::ACK_BIT) begin
						next_shreg = {shreg[6:0], sda_s};
						next_bit_cnt = bit_cnt + gist_pkg::BIT_ONE;
					end else if (!byte_idx && !sda_s) begin
						next_byte_idx = 1'b1;
						next_bit_cnt = gist_pkg::FIRST_BIT;
						next_shreg = rnw_q ? gist_pkg::RELEASE_BYTE : wdata_q;
					end else begin
						next_state = gist_pkg::H_STOP_LOW;
						next_ack_err = sda_s && !(byte_idx && rnw_q);
						if (byte_idx && rnw_q) begin
							next_rdata = shreg;
						end
					end
				end
			end
			gist_pkg::H_STOP_LOW: begin
				next_sda_oe = 1'b1;
				if (t == gist_pkg::HALF_LAST) begin
					next_scl_oe = 1'b0;
					next_state = gist_pkg::H_STOP_RISE;
					next_t = '0;
				end
			end
			gist_pkg::H_STOP_HIGH: begin
				if (t == gist_pkg::HALF_LAST) begin
					next_sda_oe = 1'b0;
					next_done = 1'b1;
					next_state = gist_pkg::H_GAP;
					next_t = '0;
				end
			end
			default: begin
				if (t >= gap_len) begin
					next_state = gist_pkg::H_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= gist_pkg::H_IDLE;
			t <= '0;
			gap_len <= '0;
			std_cnt <= STD_SPACING_CYC;
			bit_cnt <= gist_pkg::FIRST_BIT;
			byte_idx <= 1'b0;
			rnw_q <= 1'b0;
			shreg <= '0;
			wdata_q <= '0;
			rdata <= '0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			done <= 1'b0;
			ack_err <= 1'b0;
			stretch_err <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			t <= next_t;
			gap_len <= next_gap_len;
			std_cnt <= next_std_cnt;
			bit_cnt <= next_bit_cnt;
			byte_idx <= next_byte_idx;
			rnw_q <= next_rnw_q;
			shreg <= next_shreg;
			wdata_q <= next_wdata_q;
			rdata <= next_rdata;
			scl_oe <= next_scl_oe;
			sda_oe <= next_sda_oe;
			done <= next_done;
			ack_err <= next_ack_err;
			stretch_err <= next_stretch_err;
		end
	end
endmodule // gist_host

/* tb/gist_assertions.sv */
// Purpose: Line checks of the gauge end on the shared link.
// Assumes: One clock; scl and sda are wired-AND levels.
// Notes: Long holds are counted in helper counters, not repeated.
`timescale 1ns/1ns
module gist_assertions #(
	parameter gist_pkg::gist_timer_t BUS_TIMEOUT_CYC = 28'h4e20,
	parameter gist_pkg::gist_timer_t FLOW_CYC = 28'ha,
	parameter gist_pkg::gist_timer_t EOD_CYC = 28'h4b0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic dev_scl_oe,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	gist_pkg::gist_timer_t low_cnt, st_cnt;
	logic frame, scl_q, sda_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_cnt <= 28'h0;
			st_cnt <= 28'h0;
			frame <= 1'b0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			low_cnt <= (scl && sda) ? 28'h0 : low_cnt + 28'h1;
			st_cnt <= dev_scl_oe ? st_cnt + 28'h1 : 28'h0;
			scl_q <= scl;
			sda_q <= sda;
			// A start or a stop leaves the frame at the old data level.
			if (scl_q && scl && sda_q != sda)
				frame <= sda_q;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Eight spare clocks cover the gauge's line synchronisers.
	property p_free;
		low_cnt > BUS_TIMEOUT_CYC + 28'h8 |-> !dev_scl_oe && !dev_sda_oe;
	endproperty
	a_free: assert property (p_free) else $error("lines kept");
	property p_hold;
		$rose(dev_scl_oe) |-> dev_scl_oe [*8];
	endproperty
	a_hold: assert property (p_hold) else $error("hold cut");
	property p_cap;
		st_cnt <= EOD_CYC;
	endproperty
	a_cap: assert property (p_cap) else $error("hold too long");
	property p_floor;
		$fell(dev_scl_oe) |-> st_cnt >= FLOW_CYC;
	endproperty
	a_floor: assert property (p_floor) else $error("hold short");
	property p_grab;
		$rose(dev_scl_oe) |-> !$past(scl);
	endproperty
	a_grab: assert property (p_grab) else $error("grab on high");
	property p_ack;
		$rose(dev_sda_oe) |-> !$past(scl) && !scl;
	endproperty
	a_ack: assert property (p_ack) else $error("data on high");
	property p_steady;
		scl && $past(scl) |-> $stable(dev_sda_oe);
	endproperty
	a_steady: assert property (p_steady) else $error("data moved");
	property p_frame;
		dev_scl_oe |-> frame;
	endproperty
	a_frame: assert property (p_frame) else $error("idle hold");
	c_eod: cover property (st_cnt == EOD_CYC);
	c_frame: cover property ($rose(frame));
	c_ack: cover property ($rose(dev_sda_oe));
	c_free: cover property (low_cnt > BUS_TIMEOUT_CYC);
endmodule // gist_assertions

/* tb/tb_gauge_i2c_slave_timing.sv */
// Purpose: Host transfers across the link into the gauge end.
// Assumes: Shortened flash, gap and timeout counts.
// Notes: Stretch length is the longest gauge hold of the clock line.
`timescale 1ns/1ns
module tb_gauge_i2c_slave_timing;
	localparam int OPL[5] = '{300, 600, 900, 1200, 800};
	localparam int GAPL[3] = '{50, 100, 200};
	localparam int WK = 20;
	localparam int FL = 10;
	logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, rnw = 1'b0;
	logic op_req = 1'b0, dis = 1'b0, rx_seen = 1'b0;
	logic hce = 1'b1, dce = 1'b1;
	logic [6:0] addr = 7'h0;
	logic [7:0] wdata = 8'h0, tx = 8'ha5, rx_data, rdata;
	logic rx_valid, ready, done, ack_err, serr, str, bus_to;
	gist_pkg::gist_gap_e gap = gist_pkg::GAP_RO_STD;
	gist_pkg::gist_power_e pm = gist_pkg::PM_NORMAL;
	gist_pkg::gist_op_e op = gist_pkg::OP_TABLE_UPDATE;
	int mismatches = 0, n_compared = 0, top = 0, run = 0, gapc = 0;
	gist_if lnk ();
	gist_device #(.BUS_TIMEOUT_CYC(28'h4e20), .WAKE_CYC(28'(WK)),
		.FLOW_CYC(28'(FL)), .TABLE_CYC(28'(OPL[0])), .BLOCK_CYC(28'(OPL[1])),
		.RESTORE_CYC(28'(OPL[2])), .EOD_CYC(28'(OPL[3])),
		.EOD_PLAIN_CYC(28'(OPL[4]))) u_gist_device (.clk(clk), .rst_n(rst_n),
		.ce(dce), .link(lnk.dev), .power_mode(pm), .op_req(op_req),
		.op_kind(op), .discharge_start(dis), .tx_data(tx), .rx_data(rx_data),
		.rx_valid(rx_valid), .stretching(str), .bus_timeout(bus_to));
	gist_host #(.SUBCMD_GAP_CYC(28'(GAPL[0])),
		.CHECKSUM_GAP_CYC(28'(GAPL[1])), .RW_STD_GAP_CYC(28'(GAPL[2])),
		.STD_SPACING_CYC(28'h12c), .STRETCH_LIMIT_CYC(28'h1388))
		u_gist_host (.clk(clk), .rst_n(rst_n), .ce(hce), .link(lnk.host),
		.start(start), .addr(addr), .rnw(rnw), .wdata(wdata), .gap_kind(gap),
		.ready(ready), .done(done), .rdata(rdata), .ack_err(ack_err),
		.stretch_err(serr));
	gist_assertions #(.BUS_TIMEOUT_CYC(28'h4e20), .FLOW_CYC(28'(FL)),
		.EOD_CYC(28'(OPL[3]))) u_gist_assertions (.clk(clk), .rst_n(rst_n),
		.dev_scl_oe(lnk.dev_scl_oe), .dev_sda_oe(lnk.dev_sda_oe),
		.scl(lnk.scl), .sda(lnk.sda));
	initial begin
		forever #5 clk = ~clk;
	end
	// Sampled on the falling edge so that registered outputs have settled.
	always @(negedge clk) begin
		run = str ? run + 1 : 0;
		if (run > top)
			top = run;
		if (rx_valid === 1'b1)
			rx_seen = 1'b1;
	end
	task automatic stop_test;
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic [6:0] a, input logic r,
		input logic [7:0] d, input gist_pkg::gist_gap_e g);
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		start <= 1'b1;
		addr <= a;
		rnw <= r;
		wdata <= d;
		gap <= g;
		top = 0;
		rx_seen = 1'b0;
		@(posedge clk);
		start <= 1'b0;
		while (done !== 1'b1 && n < 40000) begin
			@(negedge clk);
			n++;
		end
		gapc = 0;
		while (ready !== 1'b1 && gapc < 20000) begin
			@(negedge clk);
			gapc++;
		end
		if (n >= 40000 || gapc >= 20000) begin
			mismatches++;
			stop_test;
		end
	endtask
	task automatic post(input logic ak, input int st, input int g);
		check(ack_err, ak);
		check(serr, 1'b0);
		check(top, st);
		check(gapc + 3 >= g && gapc <= g + 3, 1'b1);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		xfer(7'h55, 1'b0, 8'h3c, gist_pkg::GAP_SUBCMD);
		post(1'b0, FL, GAPL[0]);
		check(rx_data, 8'h3c);
		check(rx_seen, 1'b1);
		$display("end of own write");
		xfer(7'h55, 1'b1, 8'h00, gist_pkg::GAP_CHECKSUM);
		post(1'b0, FL, GAPL[1]);
		check(rdata, 8'ha5);
		$display("end of own read");
		// Freezing the host mid-acknowledge leaves both lines held low.
		fork
			xfer(7'h55, 1'b0, 8'h3c, gist_pkg::GAP_SUBCMD);
			begin
				for (int k = 0; k < 5000 && !lnk.dev_sda_oe; k++)
					@(negedge clk);
				check(lnk.dev_sda_oe, 1'b1);
				@(posedge clk);
				hce <= 1'b0;
				repeat (20100) @(posedge clk);
				check(bus_to, 1'b1);
				check(lnk.dev_sda_oe, 1'b0);
				hce <= 1'b1;
			end
		join
		post(1'b1, 0, GAPL[0]);
		check(bus_to, 1'b0);
		$display("end of bus timeout");
		for (int m = 0; m < 4; m++) begin
			pm <= gist_pkg::gist_power_e'(m);
			xfer(7'h22, 1'b0, 8'h5a, gist_pkg::GAP_RW_STD);
			post(1'b1, m > 1 ? WK : 0, GAPL[2]);
		end
		$display("end of foreign address");
		pm <= gist_pkg::PM_NORMAL;
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			dis <= i == 0 || i == 4;
			@(posedge clk);
			dis <= 1'b0;
			op_req <= 1'b1;
			op <= gist_pkg::gist_op_e'(i < 4 ? i : 3);
			@(posedge clk);
			op_req <= 1'b0;
			xfer(7'h55, 1'b0, 8'h81, gist_pkg::GAP_RO_STD);
			post(1'b0, OPL[i], 0);
		end
		$display("end of flash stretches");
		stop_test;
	end
endmodule // tb_gauge_i2c_slave_timing
